// ==== src/charger_setpoint_regs_timeout.sv ====
`timescale 1ns/1ps
`include "charger_regs.svh"

module charger_setpoint_regs_timeout
    import charger_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int WRITE_TIMEOUT_TICKS = `WRITE_TIMEOUT_TICKS,
    parameter int SCL_LOW_TIMEOUT_TICKS = `SCL_LOW_TIMEOUT_TICKS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register access from the byte engine
    input wire logic wr_valid,
    input wire reg_write_t wr_req,
    input wire logic rd_valid,
    input wire reg_read_t rd_req,
    input wire logic bus_stop,
    output logic wr_ack,
    output logic [15:0] rd_data,
    // pins and comparators
    input wire logic scl_in,
    input wire logic batt_under_fold,
    input wire logic batt_over_restore,
    // converter and status
    output logic [5:0] charge_converter_code,
    output logic [5:0] input_converter_code,
    output logic charge_enable,
    output logic foldback_active,
    output logic write_timeout,
    output logic scl_timeout
);

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic scl_s;
    logic under_s;
    logic over_s;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync_a <= 3'h7;
            sync_b <= 3'h7;
        end
        else
        begin
            sync_a <= {scl_in, batt_under_fold, batt_over_restore};
            sync_b <= sync_a;
        end
    end

    assign scl_s = sync_b[2];
    assign under_s = sync_b[1] & ~sync_b[0];
    assign over_s = sync_b[0];

    // ------------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------------
    function automatic logic [5:0] charge_code(input logic [15:0] val);
        logic [5:0] code;
        code = val[`CODE_MSB:`CODE_LSB];
        if (val[15:`UNUSED_HIGH_LSB] != 3'h0)
            code = `CHARGE_CODE_MAX;
        return code;
    endfunction : charge_code

    function automatic logic [5:0] input_code(input logic [15:0] val);
        logic [5:0] code;
        code = val[`CODE_MSB:`CODE_LSB];
        if (val > `INPUT_CURRENT_MAX_VALUE)
            code = `INPUT_CODE_MAX;
        return code;
    endfunction : input_code

    // ------------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------------
    logic [15:0] charge_current_setpoint;
    logic [15:0] charge_voltage_setpoint;
    logic [15:0] input_current_limit;
    logic [15:0] next_charge_current_setpoint;
    logic [15:0] next_charge_voltage_setpoint;
    logic [15:0] next_input_current_limit;
    logic next_wr_ack;
    logic [15:0] next_rd_data;
    logic wr_hit;
    logic rd_hit;
    logic cv_write;

    assign wr_hit = wr_valid && (wr_req.slave_addr == `SLAVE_ADDR);
    assign rd_hit = rd_valid && (rd_req.slave_addr == `SLAVE_ADDR);
    assign cv_write = wr_hit && (wr_req.reg_addr == `REG_CHARGE_CURRENT
        || wr_req.reg_addr == `REG_CHARGE_VOLTAGE);

    always_comb
    begin
        next_charge_current_setpoint = charge_current_setpoint;
        next_charge_voltage_setpoint = charge_voltage_setpoint;
        next_input_current_limit = input_current_limit;
        next_wr_ack = 1'b0;
        next_rd_data = rd_data;
        if (wr_hit)
        begin
            next_wr_ack = 1'b1;
            case (wr_req.reg_addr)
                `REG_CHARGE_CURRENT: next_charge_current_setpoint = wr_req.data;
                `REG_CHARGE_VOLTAGE: next_charge_voltage_setpoint = wr_req.data;
                `REG_INPUT_CURRENT: next_input_current_limit = wr_req.data;
                default: next_wr_ack = 1'b0;
            endcase
        end
        // word handed whole; byte order in engine
        if (rd_hit)
        begin
            case (rd_req.reg_addr)
                `REG_CHARGE_CURRENT: next_rd_data = charge_current_setpoint;
                `REG_CHARGE_VOLTAGE: next_rd_data = charge_voltage_setpoint;
                `REG_INPUT_CURRENT: next_rd_data = input_current_limit;
                default: next_rd_data = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            charge_current_setpoint <= `CHARGE_CURRENT_RESET;
            charge_voltage_setpoint <= `CHARGE_VOLTAGE_RESET;
            input_current_limit <= `INPUT_CURRENT_RESET;
            wr_ack <= 1'b0;
            rd_data <= 16'h0000;
        end
        else
        begin
            charge_current_setpoint <= next_charge_current_setpoint;
            charge_voltage_setpoint <= next_charge_voltage_setpoint;
            input_current_limit <= next_input_current_limit;
            wr_ack <= next_wr_ack;
            rd_data <= next_rd_data;
        end
    end

    // ------------------------------------------------------------------------
    // applied setpoints
    // ------------------------------------------------------------------------
    logic [15:0] applied_current;
    logic [15:0] applied_voltage;
    logic [15:0] applied_input;
    logic [15:0] next_applied_current;
    logic [15:0] next_applied_voltage;
    logic [15:0] next_applied_input;

    always_comb
    begin
        next_applied_current = applied_current;
        next_applied_voltage = applied_voltage;
        next_applied_input = applied_input;
        if (bus_stop)
        begin
            next_applied_current = next_charge_current_setpoint;
            next_applied_voltage = next_charge_voltage_setpoint;
            next_applied_input = next_input_current_limit;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            applied_current <= `CHARGE_CURRENT_RESET;
            applied_voltage <= `CHARGE_VOLTAGE_RESET;
            applied_input <= `INPUT_CURRENT_RESET;
        end
        else
        begin
            applied_current <= next_applied_current;
            applied_voltage <= next_applied_voltage;
            applied_input <= next_applied_input;
        end
    end

    // ------------------------------------------------------------------------
    // watchdog timers
    // ------------------------------------------------------------------------
    // restart on charge current or charge voltage write
    timeout_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .LIMIT_TICKS(WRITE_TIMEOUT_TICKS)
    ) u_write_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .restart(cv_write),
        .expired(write_timeout)
    );

    timeout_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .LIMIT_TICKS(SCL_LOW_TIMEOUT_TICKS)
    ) u_scl_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .restart(scl_s),
        .expired(scl_timeout)
    );

    // ------------------------------------------------------------------------
    // charge state
    // ------------------------------------------------------------------------
    charge_state_t state;
    charge_state_t next_state;
    logic setpoints_valid;
    logic timeout_hit;
    logic next_charge_enable;
    logic [5:0] next_charge_converter_code;
    logic [5:0] next_input_converter_code;
    logic next_foldback_active;

    assign setpoints_valid = (next_applied_current > `CHARGE_CURRENT_MIN_VALID)
        && (next_applied_voltage > `CHARGE_VOLTAGE_MIN_VALID);
    assign timeout_hit = (write_timeout && !cv_write) || scl_timeout;

    always_comb
    begin
        next_foldback_active = foldback_active;
        if (under_s)
            next_foldback_active = 1'b1;
        else if (over_s)
            next_foldback_active = 1'b0;
        next_state = state;
        case (state)
            ST_DISABLED:
            begin
                if (timeout_hit)
                    next_state = ST_TIMED_OUT;
                else if (setpoints_valid)
                    next_state = ST_CHARGING;
            end
            ST_CHARGING:
            begin
                if (timeout_hit)
                    next_state = ST_TIMED_OUT;
                else if (!setpoints_valid)
                    next_state = ST_DISABLED;
            end
            ST_TIMED_OUT:
            begin
                if (cv_write && !timeout_hit)
                    next_state = ST_DISABLED;
            end
            default: next_state = ST_DISABLED;
        endcase
        next_charge_enable = (next_state == ST_CHARGING);
        next_charge_converter_code = `CODE_OFF;
        if (next_charge_enable)
            next_charge_converter_code = charge_code(next_applied_current);
        if (next_charge_enable && next_foldback_active)
            next_charge_converter_code = `FOLDBACK_CODE;
        next_input_converter_code = input_code(next_applied_input);
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_DISABLED;
            charge_enable <= 1'b0;
            foldback_active <= 1'b0;
            charge_converter_code <= `CODE_OFF;
            input_converter_code <= `CODE_OFF;
        end
        else
        begin
            state <= next_state;
            charge_enable <= next_charge_enable;
            foldback_active <= next_foldback_active;
            charge_converter_code <= next_charge_converter_code;
            input_converter_code <= next_input_converter_code;
        end
    end

endmodule : charger_setpoint_regs_timeout

// ==== src/charger_regs.svh ====
`ifndef CHARGER_REGS_SVH
`define CHARGER_REGS_SVH

// ----------------------------------------------------------------------------
// bus identity and register codes
// ----------------------------------------------------------------------------
`define SLAVE_ADDR 7'h09
`define REG_CHARGE_CURRENT 8'h14
`define REG_CHARGE_VOLTAGE 8'h15
`define REG_INPUT_CURRENT 8'h3F

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CHARGE_CURRENT_RESET 16'h0000
`define CHARGE_VOLTAGE_RESET 16'h0000
`define INPUT_CURRENT_RESET 16'h0080

// ----------------------------------------------------------------------------
// field layout and limits
// ----------------------------------------------------------------------------
`define CODE_LSB 7
`define CODE_MSB 12
`define UNUSED_HIGH_LSB 13
`define CHARGE_CURRENT_MIN_VALID 16'h007F
`define CHARGE_VOLTAGE_MIN_VALID 16'h000F
`define CHARGE_CODE_MAX 6'h3F
`define INPUT_CURRENT_MAX_VALUE 16'h157E
`define INPUT_CODE_MAX 6'h2B
`define FOLDBACK_CODE 6'h01
`define CODE_OFF 6'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define TICK_NS 1000000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define TICKS_PER_S 1000
`define WRITE_TIMEOUT_S 175
`define WRITE_TIMEOUT_TICKS (`WRITE_TIMEOUT_S * `TICKS_PER_S)
`define SCL_LOW_TIMEOUT_MS 25
`define SCL_LOW_TIMEOUT_TICKS (`SCL_LOW_TIMEOUT_MS)

`endif

// ==== src/charger_pkg.sv ====
package charger_pkg;

    // register write from the byte engine
    typedef struct packed {
        logic [6:0] slave_addr;
        logic [7:0] reg_addr;
        logic [15:0] data;
    } reg_write_t;

    // register read request from the byte engine
    typedef struct packed {
        logic [6:0] slave_addr;
        logic [7:0] reg_addr;
    } reg_read_t;

    typedef enum logic [1:0] {
        ST_DISABLED,
        ST_CHARGING,
        ST_TIMED_OUT
    } charge_state_t;

endpackage : charger_pkg

// ==== src/timeout_timer.sv ====
`timescale 1ns/1ps

module timeout_timer #(
    parameter int TICK_CYCLES = 10000,
    parameter int LIMIT_TICKS = 25,
    parameter int PW = $clog2(TICK_CYCLES + 1),
    parameter int TW = $clog2(LIMIT_TICKS + 1)
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // control
    input wire logic restart,
    // status
    output logic expired
);

    logic [PW-1:0] pre;
    logic [PW-1:0] next_pre;
    logic [TW-1:0] ticks;
    logic [TW-1:0] next_ticks;
    logic next_expired;

    // ------------------------------------------------------------------------
    // prescaler and tick counter
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_pre = pre;
        next_ticks = ticks;
        if (restart)
        begin
            next_pre = '0;
            next_ticks = '0;
        end
        else if (ticks != TW'(LIMIT_TICKS))
        begin
            if (pre == PW'(TICK_CYCLES - 1))
            begin
                next_pre = '0;
                next_ticks = ticks + 1'b1;
            end
            else
            begin
                next_pre = pre + 1'b1;
            end
        end
        // holds until the next restart
        next_expired = !restart && (next_ticks == TW'(LIMIT_TICKS));
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre <= '0;
            ticks <= '0;
            expired <= 1'b0;
        end
        else
        begin
            pre <= next_pre;
            ticks <= next_ticks;
            expired <= next_expired;
        end
    end

endmodule : timeout_timer

// ==== bench/charger_checker.sv ====
`timescale 1ns/1ps

module charger_checker
    import charger_pkg::*;
#(
    parameter int TICK_CYCLES = 10000,
    parameter int WRITE_TIMEOUT_TICKS = 175000,
    parameter int SCL_LOW_TIMEOUT_TICKS = 25
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register access
    input wire logic wr_valid,
    input wire reg_write_t wr_req,
    input wire logic rd_valid,
    input wire reg_read_t rd_req,
    input wire logic bus_stop,
    input wire logic wr_ack,
    input wire logic [15:0] rd_data,
    // pins and comparators
    input wire logic scl_in,
    input wire logic batt_under_fold,
    input wire logic batt_over_restore,
    // converter and status
    input wire logic [5:0] charge_converter_code,
    input wire logic [5:0] input_converter_code,
    input wire logic charge_enable,
    input wire logic foldback_active,
    input wire logic write_timeout,
    input wire logic scl_timeout
);
    localparam int SCL_LO = (SCL_LOW_TIMEOUT_TICKS - 1) * TICK_CYCLES;
    localparam int SCL_HI = (SCL_LOW_TIMEOUT_TICKS + 1) * TICK_CYCLES + 4;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    logic wr_hit;
    logic wr_chg;
    logic rd_miss;
    logic [31:0] low_cnt;
    logic [31:0] next_low_cnt;
    assign wr_chg = wr_req.slave_addr == 7'h09 &&
        (wr_req.reg_addr == 8'h14 || wr_req.reg_addr == 8'h15);
    assign wr_hit = wr_chg || (wr_req.slave_addr == 7'h09 && wr_req.reg_addr == 8'h3F);
    assign rd_miss = rd_req.slave_addr == 7'h09 && rd_req.reg_addr != 8'h14 &&
        rd_req.reg_addr != 8'h15 && rd_req.reg_addr != 8'h3F;

    // ------------------------------------------------------------------
    // scl low run length
    // ------------------------------------------------------------------
    always_comb
    begin
        next_low_cnt = scl_in ? 32'h0 : low_cnt + 32'h1;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            low_cnt <= 32'h0;
        else
            low_cnt <= next_low_cnt;
    end

    AST_WR_ACK: assert property (wr_valid && wr_hit |=> wr_ack)
        else $error("mapped write not acknowledged");
    AST_NO_ACK: assert property (!(wr_valid && wr_hit) |=> !wr_ack)
        else $error("foreign write acknowledged");
    AST_RD_ZERO: assert property (rd_valid && rd_miss |=> rd_data == 16'h0000)
        else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!rd_valid |=> $stable(rd_data))
        else $error("read data moved without request");
    AST_CODE_OFF: assert property (!charge_enable |-> charge_converter_code == 6'h00)
        else $error("charge code while disabled");
    AST_FOLD: assert property (charge_enable && foldback_active |-> charge_converter_code == 6'h01)
        else $error("foldback code wrong");
    AST_IN_MAX: assert property (input_converter_code <= 6'h2B)
        else $error("input code above maximum");
    AST_SCL_STOP: assert property (scl_timeout |=> !charge_enable)
        else $error("charging during clock low timeout");
    AST_SCL_EARLY: assert property ($rose(scl_timeout) |-> low_cnt >= SCL_LO)
        else $error("clock low timeout too early");
    AST_SCL_LATE: assert property (low_cnt == SCL_HI |-> scl_timeout)
        else $error("clock low timeout too late");
    AST_WT_CLEAR: assert property (wr_valid && wr_chg |=> !write_timeout)
        else $error("write timeout not cleared");
endmodule : charger_checker

bind charger_setpoint_regs_timeout charger_checker #(
    .TICK_CYCLES(TICK_CYCLES),
    .WRITE_TIMEOUT_TICKS(WRITE_TIMEOUT_TICKS),
    .SCL_LOW_TIMEOUT_TICKS(SCL_LOW_TIMEOUT_TICKS)
) i_charger_checker (
    .core_clk(core_clk), .rst_b(rst_b), .wr_valid(wr_valid), .wr_req(wr_req),
    .rd_valid(rd_valid), .rd_req(rd_req), .bus_stop(bus_stop), .wr_ack(wr_ack),
    .rd_data(rd_data), .scl_in(scl_in), .batt_under_fold(batt_under_fold),
    .batt_over_restore(batt_over_restore), .charge_converter_code(charge_converter_code),
    .input_converter_code(input_converter_code), .charge_enable(charge_enable),
    .foldback_active(foldback_active), .write_timeout(write_timeout),
    .scl_timeout(scl_timeout)
);

// ==== bench/host_master.sv ====
`timescale 1ns/1ps

module host_master
    import charger_pkg::*;
(
    // clock and answers
    input wire logic core_clk,
    input wire logic wr_ack,
    input wire logic [15:0] rd_data,
    // requests and clock pin
    output logic wr_valid,
    output reg_write_t wr_req,
    output logic rd_valid,
    output reg_read_t rd_req,
    output logic bus_stop,
    output logic scl_in
);
    initial
    begin
        wr_valid = 1'b0;
        wr_req = '0;
        rd_valid = 1'b0;
        rd_req = '0;
        bus_stop = 1'b0;
        scl_in = 1'b1;
    end

    task automatic write_word(input logic [6:0] sa, input logic [7:0] ra,
        input logic [15:0] d, input logic stop, output logic ack);
        logic [7:0] lo;
        logic [7:0] hi;
        lo = d[7:0];
        hi = d[15:8];
        repeat (4)
        begin
            repeat (4) @(negedge core_clk);
            scl_in = ~scl_in;
        end
        @(negedge core_clk);
        wr_req = '{slave_addr: sa, reg_addr: ra, data: {hi, lo}};
        wr_valid = 1'b1;
        @(negedge core_clk);
        wr_valid = 1'b0;
        wr_req = ~wr_req;
        ack = wr_ack;
        if (stop)
            send_stop();
    endtask : write_word

    task automatic send_stop();
        bus_stop = 1'b1;
        @(negedge core_clk);
        bus_stop = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : send_stop

    task automatic read_word(input logic [7:0] ra, output logic [15:0] d);
        @(negedge core_clk);
        rd_req = '{slave_addr: 7'h09, reg_addr: ra};
        rd_valid = 1'b1;
        @(negedge core_clk);
        rd_valid = 1'b0;
        rd_req = ~rd_req;
        d = rd_data;
    endtask : read_word

    task automatic hold_scl_low(input int n);
        @(negedge core_clk);
        scl_in = 1'b0;
        repeat (n) @(negedge core_clk);
        scl_in = 1'b1;
    endtask : hold_scl_low
endmodule : host_master

// ==== bench/tb.sv ====
`timescale 1ns/1ps

module tb;
    import charger_pkg::*;
    logic core_clk, rst_b, wr_valid, rd_valid, bus_stop, wr_ack, scl_in;
    logic batt_under_fold, batt_over_restore, charge_enable, foldback_active;
    logic write_timeout, scl_timeout, ack;
    reg_write_t wr_req;
    reg_read_t rd_req;
    logic [15:0] rd_data, rd;
    logic [5:0] charge_converter_code, input_converter_code;
    int fail_count = 0;
    int cmp_count = 0;
    logic [15:0] in_val [6] = '{16'h007F, 16'h0080, 16'h1000, 16'h157E, 16'h157F, 16'hFFFF};
    logic [5:0] in_code [6] = '{6'h00, 6'h01, 6'h20, 6'h2A, 6'h2B, 6'h2B};
    logic [15:0] ch_val [5] = '{16'h2000, 16'hFFFF, 16'h1F80, 16'h007F, 16'h0000};
    logic [5:0] ch_code [5] = '{6'h3F, 6'h3F, 6'h3F, 6'h00, 6'h00};
    logic ch_en [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    charger_setpoint_regs_timeout #(.TICK_CYCLES(8), .WRITE_TIMEOUT_TICKS(20),
        .SCL_LOW_TIMEOUT_TICKS(5)) i_charger_setpoint_regs_timeout (
        .core_clk(core_clk), .rst_b(rst_b), .wr_valid(wr_valid), .wr_req(wr_req),
        .rd_valid(rd_valid), .rd_req(rd_req), .bus_stop(bus_stop), .wr_ack(wr_ack),
        .rd_data(rd_data), .scl_in(scl_in), .batt_under_fold(batt_under_fold),
        .batt_over_restore(batt_over_restore), .charge_converter_code(charge_converter_code),
        .input_converter_code(input_converter_code), .charge_enable(charge_enable),
        .foldback_active(foldback_active), .write_timeout(write_timeout),
        .scl_timeout(scl_timeout));

    host_master host (.core_clk(core_clk), .wr_ack(wr_ack), .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_req(wr_req), .rd_valid(rd_valid), .rd_req(rd_req),
        .bus_stop(bus_stop), .scl_in(scl_in));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic put(input logic [7:0] ra, input logic [15:0] d);
        host.write_word(7'h09, ra, d, 1'b1, ack);
        check(16'(ack), 16'h0001);
    endtask : put

    initial
    begin
        #1ms;
        fail_count++;
        results();
    end

    initial
    begin
        rst_b = 1'b0;
        batt_under_fold = 1'b0;
        batt_over_restore = 1'b0;
        repeat (16) @(negedge core_clk);
        rst_b = 1'b1;
        host.read_word(8'h14, rd);
        check(rd, 16'h0000);
        host.read_word(8'h3F, rd);
        check(rd, 16'h0080);
        check(16'(input_converter_code), 16'h0001);
        host.read_word(8'hFE, rd);
        check(rd, 16'h0000);
        host.write_word(7'h0A, 8'h14, 16'h0400, 1'b1, ack);
        check(16'(ack), 16'h0000);
        $display("reset and decode test done");
        for (int i = 0; i < 6; i++)
        begin
            put(8'h3F, in_val[i]);
            check(16'(input_converter_code), 16'(in_code[i]));
            host.read_word(8'h3F, rd);
            check(rd, in_val[i]);
        end
        $display("input limit test done");
        put(8'h14, 16'h0400);
        check(16'(charge_enable), 16'h0000);
        put(8'h15, 16'h000F);
        check(16'(charge_enable), 16'h0000);
        put(8'h15, 16'h0010);
        check(16'(charge_enable), 16'h0001);
        for (int b = 7; b < 13; b++)
        begin
            put(8'h14, 16'h0001 << b);
            check(16'(charge_converter_code), 16'h0001 << (b - 7));
        end
        for (int i = 0; i < 5; i++)
        begin
            put(8'h14, ch_val[i]);
            check(16'(charge_converter_code), 16'(ch_code[i]));
            check(16'(charge_enable), 16'(ch_en[i]));
            host.read_word(8'h14, rd);
            check(rd, ch_val[i]);
        end
        $display("charge current test done");
        put(8'h14, 16'h0400);
        host.write_word(7'h09, 8'h14, 16'h0800, 1'b0, ack);
        check(16'(charge_converter_code), 16'h0008);
        host.send_stop();
        check(16'(charge_converter_code), 16'h0010);
        batt_under_fold = 1'b1;
        repeat (5) @(negedge core_clk);
        check(16'(charge_converter_code), 16'h0001);
        check(16'(foldback_active), 16'h0001);
        host.read_word(8'h14, rd);
        check(rd, 16'h0800);
        batt_under_fold = 1'b0;
        batt_over_restore = 1'b1;
        repeat (5) @(negedge core_clk);
        check(16'(charge_converter_code), 16'h0010);
        check(16'(foldback_active), 16'h0000);
        batt_over_restore = 1'b0;
        $display("stop and foldback test done");
        host.hold_scl_low(60);
        check(16'(scl_timeout), 16'h0001);
        check(16'(charge_enable), 16'h0000);
        repeat (4) @(negedge core_clk);
        check(16'(scl_timeout), 16'h0000);
        put(8'h14, 16'h0800);
        check(16'(charge_enable), 16'h0001);
        for (int n = 0; n < 300 && write_timeout !== 1'b1; n++)
            @(negedge core_clk);
        check(16'(write_timeout), 16'h0001);
        @(negedge core_clk);
        check(16'(charge_enable), 16'h0000);
        put(8'h15, 16'h0010);
        check(16'(write_timeout), 16'h0000);
        check(16'(charge_enable), 16'h0001);
        $display("timeout test done");
        results();
    end
endmodule : tb
